// >>> src/bdc_map.svh
// Purpose: Offsets-free constant map for the bus DRAM board controller
// Assumes: Clock period of 8 ns
// Notes: Cycle counts are derived from the times in ns
`ifndef BDC_MAP_SVH
`define BDC_MAP_SVH

`define BDC_CLK_NS 8
`define BDC_ACC_NS 330
`define BDC_CYC_NS 450
`define BDC_AACK_STEP_NS 100
`define BDC_REF_INT_NS 15600
// All times round down to whole cycles
`define BDC_ACC_CYC (`BDC_ACC_NS / `BDC_CLK_NS)
`define BDC_CYC_CYC (`BDC_CYC_NS / `BDC_CLK_NS)
`define BDC_AACK_STEP_CYC (`BDC_AACK_STEP_NS / `BDC_CLK_NS)
`define BDC_REF_INT_CYC (`BDC_REF_INT_NS / `BDC_CLK_NS)
// Edges from a command pin to the sequencer taking it
`define BDC_SYNC_LAT 5
`define BDC_CNT_W 6
`define BDC_REF_CNT_W 12
`define BDC_REF_ROW_W 7
`define BDC_SYNC_W 6
`define BDC_SYNC_MRD 0
`define BDC_SYNC_MWR 1
`define BDC_SYNC_IRD 2
`define BDC_SYNC_IWR 3
`define BDC_SYNC_INH 4
`define BDC_SYNC_BTN 5

`endif

// >>> src/bdc_pkg.sv
// Purpose: Types for the bus DRAM board controller
// Assumes: Nothing
// Notes: State codes written out in binary
package bdc_pkg;
    typedef enum logic [1:0] {
        BDC_IDLE = 2'b00,
        BDC_ACCESS = 2'b01,
        BDC_REFRESH = 2'b10,
        BDC_IOACK = 2'b11
    } bdc_state_t;
endpackage

// >>> src/bdc_board_ctrl.sv
// Purpose: Control logic of a two-section dynamic RAM board on a system bus
// Assumes: Address, data, byte-high enable and straps stable while a command is active
// Notes: Bus strobes, inhibit and error button pass a three-stage synchroniser and a fourth register that updates when two stages agree
//
// Summary of operation
// [RULE1] Read data is ready within 330 ns when no refresh runs.
// [RULE2] A full memory cycle including recovery lasts 450 ns.
// [RULE3] An access arriving during refresh waits for it, up to 880 ns.
// [RULE4] Refresh is generated internally and placed after any running access.
// [RULE5] Two 64K sections, each placed on its own 64K boundary.
// [RULE6] Only enabled 16K banks of a section respond; others are ignored.
// [RULE7] All 24 address lines are decoded, a 16 MB space.
// [RULE8] Each section matches upper address lines exactly against its 8-bit switch.
// [RULE9] Port address compares A0-A7 always, A8-A15 only with wide decode.
// [RULE10] Optionally a selected vectored interrupt line stands while an error is latched.
// [RULE11] Reading the status port returns the failing RAM group.
// [RULE12] Writing the status port clears the error and the interrupt.
// [RULE13] Three indicators show the failing group; manual reset clears the error.
// [RULE14] Transfer acknowledge rises when the memory transfer completes, within 330 ns.
// [RULE15] Advance acknowledge comes at a strapped delay after the access starts.
// [RULE16] Each section has four groups: even/odd lane by lower/upper half.
// [RULE17] Each group is nine bits: eight data bits and one parity bit.
// [RULE18] Even lane, odd lane or both are enabled from A0 and byte-high enable.
// [RULE19] A15 selects the 32K half of the addressed section.
// [RULE20] Byte transfers use D0-D7 only; odd bytes are routed there. The code does so only while byte-high enable is inactive.
// [RULE21] Word transfers move all 16 bits to both lanes unswapped.
// [RULE22] Writes store odd parity per byte; reads check it and latch errors.
// [RULE23] Status port commands are acknowledged at once, without memory timing.
// [RULE24] While RAM inhibit is asserted neither section is selected.
// [RULE25] A strap can disable the advance acknowledge entirely.
// [RULE26] The error latch holds the first failing group until cleared.
// [RULE27] An interval counter raises refresh requests granted only when no access runs.
`timescale 1ns/100ps
`include "bdc_map.svh"

module bdc_board_ctrl
    import bdc_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16,
    parameter int RAM_ADDR_W = 14
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic bhen_n_in,
    input wire logic mem_rd_n_in,
    input wire logic mem_wr_n_in,
    input wire logic io_rd_n_in,
    input wire logic io_wr_n_in,
    input wire logic inhibit_in,
    input wire logic err_reset_n_in,
    input wire logic [7:0] sect0_base_in,
    input wire logic [7:0] sect1_base_in,
    input wire logic [7:0] bank_en_in,
    input wire logic [15:0] port_addr_in,
    input wire logic wide_port_in,
    input wire logic [2:0] aack_delay_in,
    input wire logic aack_en_in,
    input wire logic int_en_in,
    input wire logic [2:0] int_sel_in,
    input wire logic [17:0] ram_rdata_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_out,
    output logic xack_out,
    output logic aack_out,
    output logic [7:0] int_out,
    output logic [2:0] err_led_out,
    output logic err_valid_out,
    output logic ram_cyc_out,
    output logic ram_refresh_out,
    output logic ram_we_out,
    output logic [1:0] ram_row_out,
    output logic [1:0] ram_lane_en_out,
    output logic [RAM_ADDR_W-1:0] ram_addr_out,
    output logic [17:0] ram_wdata_out
);

    // ==========================================================
    // Input synchronisers
    logic [`BDC_SYNC_W-1:0] raw_in;
    logic [`BDC_SYNC_W-1:0] sync1_q;
    logic [`BDC_SYNC_W-1:0] sync2_q;
    logic [`BDC_SYNC_W-1:0] sync3_q;
    logic [`BDC_SYNC_W-1:0] sync_q;

    assign raw_in = {~err_reset_n_in, inhibit_in, ~io_wr_n_in, ~io_rd_n_in, ~mem_wr_n_in, ~mem_rd_n_in};

    genvar gi;
    generate
        for (gi = 0; gi < `BDC_SYNC_W; gi++) begin : g_sync
            always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else if (ce_in) begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    if (sync2_q[gi] == sync3_q[gi]) begin
                        sync_q[gi] <= sync3_q[gi];
                    end
                end
            end
        end
    endgenerate

    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
    logic inhibit;
    logic btn;

    assign mem_rd = sync_q[`BDC_SYNC_MRD];
    assign mem_wr = sync_q[`BDC_SYNC_MWR];
    assign io_rd = sync_q[`BDC_SYNC_IRD];
    assign io_wr = sync_q[`BDC_SYNC_IWR];
    assign inhibit = sync_q[`BDC_SYNC_INH];
    assign btn = sync_q[`BDC_SYNC_BTN];

    // ==========================================================
    // Address decode
    logic sect0_hit;
    logic sect1_hit;
    logic sect_sel;
    logic bank_ok;
    logic mem_sel;
    logic port_hit;

    assign sect0_hit = (addr_in[23:16] == sect0_base_in); // [RULE5] [RULE7] [RULE8]
    assign sect1_hit = (addr_in[23:16] == sect1_base_in); // [RULE5] [RULE8]
    assign sect_sel = ~sect0_hit;
    assign bank_ok = bank_en_in[{sect_sel, addr_in[15:14]}]; // [RULE6]
    assign mem_sel = (sect0_hit | sect1_hit) & bank_ok & ~inhibit; // [RULE24]
    assign port_hit = (addr_in[7:0] == port_addr_in[7:0]) &
                      (~wide_port_in | (addr_in[15:8] == port_addr_in[15:8])); // [RULE9]

    // ==========================================================
    // Byte lane steering
    logic bhen;
    logic [1:0] lane_en;
    logic [17:0] wdata;

    assign bhen = ~bhen_n_in;
    always_comb begin
        lane_en = 2'b00;
        if (!bhen) begin
            lane_en = addr_in[0] ? 2'b10 : 2'b01; // [RULE18] [RULE20]
        end else begin
            lane_en = addr_in[0] ? 2'b10 : 2'b11; // [RULE18] [RULE21]
        end
    end

    always_comb begin
        wdata = {~^data_in[15:8], data_in[15:8], ~^data_in[7:0], data_in[7:0]}; // [RULE17] [RULE22]
        if (!bhen && addr_in[0]) begin
            wdata[17:9] = {~^data_in[7:0], data_in[7:0]}; // [RULE20]
        end
    end

    // ==========================================================
    // Refresh interval counter
    logic [`BDC_REF_CNT_W-1:0] ref_cnt_q;
    logic ref_req_q;
    bdc_state_t state_q;
    logic [`BDC_CNT_W-1:0] cnt_q;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ref_cnt_q <= '0;
            ref_req_q <= 1'b0;
        end else if (ce_in) begin
            if (ref_cnt_q == `BDC_REF_CNT_W'(`BDC_REF_INT_CYC - 1)) begin
                ref_cnt_q <= '0;
                ref_req_q <= 1'b1; // [RULE27]
            end else begin
                ref_cnt_q <= ref_cnt_q + 1'b1;
                if (state_q == BDC_REFRESH) begin
                    ref_req_q <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Cycle sequencer
    logic mem_cmd;
    logic io_cmd;
    logic acc_rd_q;
    logic acc_done;
    logic [`BDC_REF_ROW_W-1:0] ref_row_q;

    assign mem_cmd = mem_rd | mem_wr;
    assign io_cmd = (io_rd | io_wr) & port_hit;
    assign acc_done = (cnt_q == `BDC_CNT_W'(`BDC_CYC_CYC - 1));

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= BDC_IDLE;
            cnt_q <= '0;
            acc_rd_q <= 1'b0;
            ref_row_q <= '0;
        end else if (ce_in) begin
            case (state_q)
                BDC_IDLE: begin
                    cnt_q <= '0;
                    if (io_cmd) begin
                        state_q <= BDC_IOACK; // [RULE23]
                    end else if (mem_cmd && mem_sel) begin
                        state_q <= BDC_ACCESS;
                        acc_rd_q <= mem_rd;
                    end else if (ref_req_q) begin
                        state_q <= BDC_REFRESH; // [RULE4] [RULE27]
                    end
                end
                BDC_ACCESS: begin
                    if (!acc_done) begin
                        cnt_q <= cnt_q + 1'b1; // [RULE2]
                    end else if (!mem_cmd) begin
                        state_q <= BDC_IDLE;
                    end
                end
                BDC_REFRESH: begin
                    if (acc_done) begin
                        state_q <= BDC_IDLE; // [RULE3]
                        ref_row_q <= ref_row_q + 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                BDC_IOACK: begin
                    if (!(io_rd | io_wr)) begin
                        state_q <= BDC_IDLE;
                    end
                end
                default: begin
                    state_q <= BDC_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // RAM control outputs
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ram_cyc_out <= 1'b0;
            ram_refresh_out <= 1'b0;
            ram_we_out <= 1'b0;
            ram_row_out <= 2'b00;
            ram_lane_en_out <= 2'b00;
            ram_addr_out <= '0;
            ram_wdata_out <= '0;
        end else if (ce_in) begin
            if (state_q == BDC_IDLE && !io_cmd && mem_cmd && mem_sel) begin
                ram_cyc_out <= 1'b1;
                ram_we_out <= mem_wr;
                ram_row_out <= {sect_sel, addr_in[15]}; // [RULE16] [RULE19]
                ram_lane_en_out <= lane_en; // [RULE16] [RULE18]
                ram_addr_out <= addr_in[RAM_ADDR_W:1];
                ram_wdata_out <= wdata; // [RULE22]
            end else if (state_q == BDC_IDLE && !io_cmd && !(mem_cmd && mem_sel) && ref_req_q) begin
                ram_refresh_out <= 1'b1;
                ram_addr_out <= RAM_ADDR_W'(ref_row_q);
            end else if (acc_done) begin
                ram_cyc_out <= 1'b0;
                ram_refresh_out <= 1'b0;
                ram_we_out <= 1'b0;
                ram_lane_en_out <= 2'b00;
            end
        end
    end

    // ==========================================================
    // Read data capture and parity check
    logic data_ready;
    logic [1:0] par_bad;
    logic err_set;
    logic err_clr;
    logic [2:0] err_grp_d;
    logic [2:0] err_grp_q;
    logic err_q;

    // Synchroniser latency is taken off so the host sees data within the access time
    assign data_ready = (state_q == BDC_ACCESS) && (cnt_q == `BDC_CNT_W'(`BDC_ACC_CYC - `BDC_SYNC_LAT - 1));
    assign par_bad[0] = ram_lane_en_out[0] & ~(^ram_rdata_in[8:0]); // [RULE22]
    assign par_bad[1] = ram_lane_en_out[1] & ~(^ram_rdata_in[17:9]); // [RULE22]
    assign err_set = data_ready & acc_rd_q & (|par_bad);
    assign err_grp_d = {ram_row_out, ~par_bad[0]}; // [RULE16]
    assign err_clr = ((state_q == BDC_IOACK) & io_wr) | btn; // [RULE12] [RULE13]

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_q <= 1'b0;
            err_grp_q <= 3'h0;
        end else if (ce_in) begin
            if (err_set && (!err_q || err_clr)) begin
                err_q <= 1'b1; // [RULE26]
                err_grp_q <= err_grp_d;
            end else if (err_clr) begin
                err_q <= 1'b0; // [RULE12]
            end
        end
    end

    // ==========================================================
    // Host bus outputs
    logic [`BDC_CNT_W:0] aack_cyc;

    assign aack_cyc = (`BDC_CNT_W + 1)'(aack_delay_in * `BDC_AACK_STEP_CYC);

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            xack_out <= 1'b0;
            aack_out <= 1'b0;
            data_out <= '0;
            data_oe_out <= 1'b0;
        end else if (ce_in) begin
            if (state_q == BDC_IOACK) begin
                xack_out <= io_rd | io_wr; // [RULE23]
                data_oe_out <= io_rd;
                data_out <= {12'h000, err_q, err_grp_q}; // [RULE11]
            end else if (state_q == BDC_ACCESS) begin
                if (data_ready) begin
                    xack_out <= 1'b1; // [RULE1] [RULE14]
                    data_oe_out <= acc_rd_q;
                    if (ram_lane_en_out == 2'b10 && bhen_n_in) begin
                        data_out <= {8'h00, ram_rdata_in[16:9]}; // [RULE20]
                    end else begin
                        data_out <= {ram_rdata_in[16:9], ram_rdata_in[7:0]}; // [RULE21]
                    end
                end else if (!mem_cmd) begin
                    xack_out <= 1'b0;
                    data_oe_out <= 1'b0;
                end
            end else begin
                xack_out <= 1'b0;
                data_oe_out <= 1'b0;
            end
            if (state_q == BDC_ACCESS && mem_cmd && {1'b0, cnt_q} >= aack_cyc) begin
                aack_out <= aack_en_in; // [RULE15] [RULE25]
            end else begin
                aack_out <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Indicators and interrupt
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_led_out <= 3'h0;
            err_valid_out <= 1'b0;
            int_out <= 8'h00;
        end else if (ce_in) begin
            err_led_out <= err_q ? err_grp_q : 3'h0; // [RULE13]
            err_valid_out <= err_q;
            int_out <= (err_q && int_en_in) ? (8'h01 << int_sel_in) : 8'h00; // [RULE10]
        end
    end

endmodule

// >>> tb/bdc_board_ctrl_properties.sv
// Purpose: Concurrent checks on the board controller ports
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to every controller instance
`timescale 1ns/100ps
module bdc_board_ctrl_properties
    import bdc_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16,
    parameter int RAM_ADDR_W = 14
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic bhen_n_in,
    input wire logic mem_rd_n_in,
    input wire logic io_rd_n_in,
    input wire logic inhibit_in,
    input wire logic [7:0] sect0_base_in,
    input wire logic [7:0] sect1_base_in,
    input wire logic [7:0] bank_en_in,
    input wire logic [15:0] port_addr_in,
    input wire logic wide_port_in,
    input wire logic [2:0] aack_delay_in,
    input wire logic aack_en_in,
    input wire logic int_en_in,
    input wire logic [2:0] int_sel_in,
    input wire logic xack_out,
    input wire logic aack_out,
    input wire logic [7:0] int_out,
    input wire logic [2:0] err_led_out,
    input wire logic err_valid_out,
    input wire logic ram_cyc_out,
    input wire logic ram_refresh_out,
    input wire logic ram_we_out,
    input wire logic [1:0] ram_row_out,
    input wire logic [1:0] ram_lane_en_out,
    input wire logic [RAM_ADDR_W-1:0] ram_addr_out,
    input wire logic [17:0] ram_wdata_out
);
    // ====================
    // Helpers
    logic [7:0] cnt_q;
    logic sel_ok;
    logic port_hit;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    assign sel_ok = !inhibit_in && (addr_in[23:16] == sect0_base_in ? bank_en_in[{1'b0, addr_in[15:14]}]
        : addr_in[23:16] == sect1_base_in && bank_en_in[{1'b1, addr_in[15:14]}]);
    assign port_hit = addr_in[7:0] == port_addr_in[7:0] && (!wide_port_in || addr_in[15:8] == port_addr_in[15:8]);
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 8'h00;
        end else if (!ram_cyc_out) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'hff) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    // ====================
    // Assertions
    sel_decode_a: assert property ($rose(ram_cyc_out) |-> sel_ok && ram_row_out == {addr_in[23:16] != sect0_base_in,
        addr_in[15]} && ram_lane_en_out == {addr_in[0] | !bhen_n_in, !addr_in[0]} && ram_addr_out == addr_in[14:1])
        else $error("access started on a wrong or disabled place");
    mem_ack_time_a: assert property ($rose(ram_cyc_out) |-> ##[33:36] $rose(xack_out))
        else $error("memory acknowledge late");
    slow_ack_a: assert property ($fell(mem_rd_n_in) && sel_ok |-> ##[1:110] xack_out)
        else $error("read behind refresh not acknowledged");
    io_ack_a: assert property ($fell(io_rd_n_in) && port_hit |-> ##[1:66] xack_out)
        else $error("port read not acknowledged");
    refresh_excl_a: assert property (!(ram_cyc_out && ram_refresh_out))
        else $error("refresh overlaps an access");
    aack_off_a: assert property (!aack_en_in && !$past(aack_en_in) |-> !aack_out)
        else $error("advance acknowledge while disabled");
    aack_time_a: assert property ($rose(aack_out) && ram_cyc_out |-> cnt_q + 2 >= 12 * aack_delay_in
        && cnt_q <= 12 * aack_delay_in + 2) else $error("advance acknowledge off its delay");
    parity_gen_a: assert property (ram_we_out && xack_out |-> (!ram_lane_en_out[0] || ^ram_wdata_out[8:0])
        && (!ram_lane_en_out[1] || ^ram_wdata_out[17:9])) else $error("stored parity not odd");
    int_line_a: assert property (err_valid_out && $past(err_valid_out) && int_en_in |-> int_out == 8'h01 << int_sel_in)
        else $error("interrupt line wrong");
    err_clear_a: assert property (!err_valid_out && !$past(err_valid_out) |-> int_out == 8'h00 && err_led_out == 3'h0)
        else $error("indication without error");
    led_hold_a: assert property (err_valid_out && $past(err_valid_out) |-> $stable(err_led_out))
        else $error("failing group changed while latched");
endmodule

bind bdc_board_ctrl bdc_board_ctrl_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .RAM_ADDR_W(RAM_ADDR_W))
    bdc_board_ctrl_properties_i (.sys_clk_in, .rst_n_in, .addr_in, .bhen_n_in, .mem_rd_n_in, .io_rd_n_in,
    .inhibit_in, .sect0_base_in, .sect1_base_in, .bank_en_in, .port_addr_in, .wide_port_in, .aack_delay_in,
    .aack_en_in, .int_en_in, .int_sel_in, .xack_out, .aack_out, .int_out, .err_led_out, .err_valid_out,
    .ram_cyc_out, .ram_refresh_out, .ram_we_out, .ram_row_out, .ram_lane_en_out, .ram_addr_out, .ram_wdata_out);

// >>> tb/bdc_ram_model.sv
// Purpose: RAM array behind the controller
// Assumes: Read data is combinational from row and address; lanes only gate writes
// Notes: flip_in corrupts the even parity bit on reads
`timescale 1ns/100ps
module bdc_ram_model (
    input wire logic sys_clk_in,
    input wire logic cyc_in,
    input wire logic we_in,
    input wire logic [1:0] row_in,
    input wire logic [1:0] lane_in,
    input wire logic [13:0] addr_in,
    input wire logic [17:0] wdata_in,
    input wire logic flip_in,
    output logic [17:0] rdata_out
);
    logic [8:0] even_q [logic [15:0]];
    logic [8:0] odd_q [logic [15:0]];
    logic [15:0] key;
    logic [17:0] word;
    assign key = {row_in, addr_in};
    // Four nine-bit groups per section, keyed by row and lane
    always @(posedge sys_clk_in) begin
        if (cyc_in && we_in && lane_in[0]) begin
            even_q[key] = wdata_in[8:0];
        end
        if (cyc_in && we_in && lane_in[1]) begin
            odd_q[key] = wdata_in[17:9];
        end
    end
    // Outside a cycle the lines show the inverse, never a held value
    always @* begin
        word = {odd_q.exists(key) ? odd_q[key] : 9'h100, even_q.exists(key) ? even_q[key] : 9'h100};
        rdata_out = cyc_in ? word ^ {9'h000, flip_in, 8'h00} : ~word;
    end
endmodule

// >>> tb/bdc_board_ctrl_bench.sv
// Purpose: Self-checking bench for the board controller
// Assumes: Expected read data queued by the driver
// Notes: A monitor compares data at each rising acknowledge with data_oe_out high
`timescale 1ns/100ps
module bdc_board_ctrl_bench import bdc_pkg::*;;
    logic sys_clk_in, rst_n_in, ce_in, bhen_n_in, mem_rd_n_in, mem_wr_n_in, io_rd_n_in, io_wr_n_in, xp;
    logic inhibit_in, err_reset_n_in, wide_port_in, aack_en_in, int_en_in, flip, data_oe_out, xack_out, aack_out;
    logic err_valid_out, ram_cyc_out, ram_refresh_out, ram_we_out;
    logic [23:0] addr_in;
    logic [15:0] data_in, port_addr_in, data_out;
    logic [7:0] sect0_base_in, sect1_base_in, bank_en_in, int_out;
    logic [2:0] aack_delay_in, int_sel_in, err_led_out;
    logic [17:0] ram_rdata_in, ram_wdata_out;
    logic [1:0] ram_row_out, ram_lane_en_out;
    logic [13:0] ram_addr_out;
    logic [31:0] exp_q [$];
    int n_fail, n_compared;
    bdc_board_ctrl bdc_board_ctrl_i (.sys_clk_in, .rst_n_in, .ce_in, .addr_in, .data_in, .bhen_n_in, .mem_rd_n_in,
        .mem_wr_n_in, .io_rd_n_in, .io_wr_n_in, .inhibit_in, .err_reset_n_in, .sect0_base_in, .sect1_base_in,
        .bank_en_in, .port_addr_in, .wide_port_in, .aack_delay_in, .aack_en_in, .int_en_in, .int_sel_in,
        .ram_rdata_in, .data_out, .data_oe_out, .xack_out, .aack_out, .int_out, .err_led_out, .err_valid_out,
        .ram_cyc_out, .ram_refresh_out, .ram_we_out, .ram_row_out, .ram_lane_en_out, .ram_addr_out, .ram_wdata_out);
    bdc_ram_model bdc_ram_model_i (.sys_clk_in, .cyc_in(ram_cyc_out), .we_in(ram_we_out), .row_in(ram_row_out),
        .lane_in(ram_lane_en_out), .addr_in(ram_addr_out), .wdata_in(ram_wdata_out), .flip_in(flip),
        .rdata_out(ram_rdata_in));
    // ====================
    // Tasks
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic summarize;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Kind 0 memory read, 1 memory write, 2 port read, 3 port write
    task automatic bus(input int k, input logic [23:0] a, input logic bh, input logic [15:0] d, input logic [15:0] m,
        input logic ok);
        int n;
        @(posedge sys_clk_in);
        addr_in <= a;
        data_in <= d;
        bhen_n_in <= bh;
        {mem_rd_n_in, mem_wr_n_in, io_rd_n_in, io_wr_n_in} <= {k != 0, k != 1, k != 2, k != 3};
        if (ok && k % 2 == 0) exp_q.push_back({m, d & m});
        n = 0;
        while (xack_out !== 1'b1 && n < 150) begin
            @(posedge sys_clk_in);
            n++;
        end
        chk(16'(n < 150), 16'(ok));
        @(posedge sys_clk_in);
        {mem_rd_n_in, mem_wr_n_in, io_rd_n_in, io_wr_n_in} <= 4'hf;
        repeat (24) @(posedge sys_clk_in);
    endtask
    // ====================
    // Clock, monitor, watchdog
    initial begin
        sys_clk_in = 1'b0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin : mon
        logic [31:0] e;
        if (xack_out === 1'b1 && xp !== 1'b1 && data_oe_out === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk(data_out & e[31:16], e[15:0]);
        end
        xp <= xack_out;
    end
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
    // ====================
    // Scenarios
    initial begin
        logic [23:0] a;
        logic [15:0] w;
        logic [7:0] b;
        int n;
        void'($urandom(32'h5b5b7459));
        {mem_rd_n_in, mem_wr_n_in, io_rd_n_in, io_wr_n_in, err_reset_n_in, ce_in, aack_en_in, int_en_in} = 8'hff;
        {bhen_n_in, rst_n_in, inhibit_in, wide_port_in, flip, addr_in, data_in, aack_delay_in} = '0;
        {sect0_base_in, sect1_base_in, bank_en_in, port_addr_in, int_sel_in} = {24'h1234bf, 16'h5a3c, 3'h5};
        repeat (10) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            a = {8'h12, 15'($urandom), 1'b0};
            w = 16'($urandom);
            @(posedge sys_clk_in);
            aack_delay_in <= 3'(i);
            aack_en_in <= (i != 3);
            bus(1, a, 1'b0, w, 16'h0, 1'b1);
            bus(0, a, 1'b0, w, 16'hffff, 1'b1);
        end
        b = 8'($urandom);
        bus(1, a + 1, 1'b1, {8'h00, b}, 16'h0, 1'b1);
        bus(0, a + 1, 1'b1, {8'h00, b}, 16'h00ff, 1'b1);
        bus(0, a + 1, 1'b0, {b, 8'h00}, 16'hff00, 1'b1);
        bus(0, a, 1'b0, {b, w[7:0]}, 16'hffff, 1'b1);
        bus(1, 24'h34c004, 1'b0, ~w, 16'h0, 1'b1);
        bus(0, 24'h34c004, 1'b0, ~w, 16'hffff, 1'b1);
        bus(0, 24'h348004, 1'b0, 16'h0, 16'h0, 1'b0);
        bus(0, 24'h350004, 1'b0, 16'h0, 16'h0, 1'b0);
        bus(0, 24'h920004, 1'b0, 16'h0, 16'h0, 1'b0);
        inhibit_in <= 1'b1;
        bus(0, a, 1'b0, 16'h0, 16'h0, 1'b0);
        inhibit_in <= 1'b0;
        flip <= 1'b1;
        bus(0, a, 1'b0, {b, w[7:0]}, 16'hffff, 1'b1);
        chk(16'(err_valid_out), 16'h1);
        chk(16'(err_led_out), {13'h0, 1'b0, a[15], 1'b0});
        chk(16'(int_out), 16'h0020);
        bus(0, 24'h34c004, 1'b0, ~w, 16'hffff, 1'b1);
        chk(16'(err_led_out), {13'h0, 1'b0, a[15], 1'b0});
        flip <= 1'b0;
        bus(2, 24'h00993c, 1'b1, {12'h0, 1'b1, 1'b0, a[15], 1'b0}, 16'hffff, 1'b1);
        bus(3, 24'h00993c, 1'b1, 16'h0, 16'h0, 1'b1);
        chk(16'(err_valid_out), 16'h0);
        chk(16'(int_out), 16'h0);
        wide_port_in <= 1'b1;
        bus(2, 24'h00993c, 1'b1, 16'h0, 16'h0, 1'b0);
        bus(2, 24'h005a3c, 1'b1, 16'h0, 16'hffff, 1'b1);
        flip <= 1'b1;
        bus(0, a, 1'b0, {b, w[7:0]}, 16'hffff, 1'b1);
        flip <= 1'b0;
        ce_in <= 1'b0;
        err_reset_n_in <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        chk(16'(err_valid_out), 16'h1);
        ce_in <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        err_reset_n_in <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        chk(16'(err_valid_out), 16'h0);
        n = 0;
        while (ram_refresh_out !== 1'b1 && n < 2200) begin
            @(posedge sys_clk_in);
            n++;
        end
        chk(16'(n < 2200), 16'h1);
        bus(0, a, 1'b0, {b, w[7:0]}, 16'hffff, 1'b1);
        chk(16'(exp_q.size()), 16'h0);
        summarize();
    end
endmodule
